// ### common/pts_pkg.sv
// Constants, types and shared arithmetic of the programmable threshold stage.
// How it works
// RQ1 - Up to three selected measurements, compared independently.
// RQ2 - Scale each measurement; expose the scaled value.
// RQ3 - Node behaviour code: on/blocked/test/test-blocked/off.
// RQ4 - Condition code: normal, start, trip, blocked.
// RQ5 - Expose time remaining to trip, 0..1800 s.
// RQ6 - Expose signed expected operating time.
// RQ7 - Per-channel measured to setting ratio, clamped.
// RQ8 - Combined magnitude to setting ratio, clamped.
// RQ9 - Signed pick-up level, 0.0001 steps, default 0.01.
// RQ10 - Hysteresis relative to pick-up, default 3%.
// RQ11 - Eight comparator modes per channel, default over.
// RQ12 - Operate and release delays, 5 ms steps.
// RQ13 - Start only when blocking is inactive.
// RQ14 - Blocked at pick-up stops; active start releases.
// RQ15 - Sample blocking at each program cycle start.
// RQ16 - Delta modes compare change over 20 ms.
// RQ17 - Under modes suppressed below blocking limit.
// RQ18 - Trip after operate delay; remaining time zero.
// RQ19 - Hold start until release delay after clearing.
package pts_pkg;
  localparam int VAL_W = 40;
  localparam int SCALE_FRAC = 16;
  localparam int HYST_W = 20;
  localparam int DLY_W = 19;
  localparam int TIME_W = 22;
  localparam int N_CH = 3;
  localparam longint CLK_HZ = 100000000;
  localparam longint STEP_MS = 5;
  localparam int CYCLE_CLKS = int'(CLK_HZ / 1000 * STEP_MS);
  localparam int DELTA_MS = 20;
  localparam int DELTA_TICKS = DELTA_MS / int'(STEP_MS);
  localparam logic signed [63:0] VALUE_ONE = 64'sd10000;
  localparam logic signed [63:0] HYST_FULL = 64'sd1000000;
  localparam logic signed [63:0] RATIO_LIMIT = 64'sd5000000 * VALUE_ONE;
  localparam logic signed [VAL_W-1:0] PICKUP_DEFAULT = 40'sd100;
  localparam logic [HYST_W-1:0] HYST_DEFAULT = 20'd30000;
  localparam int OP_DELAY_MS = 40;
  localparam int REL_DELAY_MS = 60;
  localparam logic [DLY_W-1:0] OP_DELAY_DEFAULT =
    DLY_W'(OP_DELAY_MS / int'(STEP_MS));
  localparam logic [DLY_W-1:0] REL_DELAY_DEFAULT =
    DLY_W'(REL_DELAY_MS / int'(STEP_MS));
  localparam logic [TIME_W-1:0] STEP_MS_W = TIME_W'(STEP_MS);

  typedef enum logic [2:0] {
    MODE_OVER = 3'h0, MODE_OVER_ABS = 3'h1, MODE_UNDER = 3'h2,
    MODE_UNDER_ABS = 3'h3, MODE_REL_SGN = 3'h4, MODE_REL_ABS = 3'h5,
    MODE_DELTA_SGN = 3'h6, MODE_DELTA_ABS = 3'h7
  } pts_mode_t;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'h0, ST_START = 2'h1, ST_TRIP = 2'h2, ST_BLOCKED = 2'h3
  } pts_state_t;

  typedef enum logic [2:0] {
    NB_ON = 3'h1, NB_BLOCKED = 3'h2, NB_TEST = 3'h3,
    NB_TEST_BLOCKED = 3'h4, NB_OFF = 3'h5
  } pts_node_t;

  // Magnitude of a 64-bit signed value.
  function automatic logic signed [63:0] pts_abs(logic signed [63:0] v);
    pts_abs = (v < 0) ? -v : v;
  endfunction

  // Value to setting ratio in 0.0001 units, clamped to the display range.
  function automatic logic signed [VAL_W-1:0] pts_ratio(
    logic signed [63:0] v, logic signed [63:0] pu);
    logic signed [63:0] r;
    if (pu == 0) begin
      r = (v < 0) ? -RATIO_LIMIT : RATIO_LIMIT;
    end else begin
      r = (v * VALUE_ONE) / pu;
    end
    if (r > RATIO_LIMIT) begin
      r = RATIO_LIMIT;
    end else if (r < -RATIO_LIMIT) begin
      r = -RATIO_LIMIT;
    end
    pts_ratio = r[VAL_W-1:0];
  endfunction
endpackage

// ### common/pts_chan_if.sv
// Interface between the stage timer and one channel comparator.
`timescale 1ns/1ps
interface pts_chan_if;
  import pts_pkg::*;
  logic tick;
  logic sel;
  logic signed [VAL_W-1:0] meas;
  logic signed [VAL_W-1:0] scale;
  logic signed [VAL_W-1:0] pickup;
  logic signed [VAL_W-1:0] block_limit;
  logic [HYST_W-1:0] hyst;
  logic [2:0] mode;
  logic active;
  logic signed [VAL_W-1:0] scaled;
  logic signed [VAL_W-1:0] ratio;
  modport cmp (input tick, sel, meas, scale, pickup, block_limit, hyst,
               mode, output active, scaled, ratio);
  modport ctl (output tick, sel, meas, scale, pickup, block_limit, hyst,
               mode, input active, scaled, ratio);
endinterface

// ### core/pts_comparator.sv
// One channel: scaling, comparator modes, hysteresis and ratio.
`timescale 1ns/1ps
module pts_comparator
  import pts_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  pts_chan_if.cmp ch
);
  logic signed [VAL_W-1:0] hist_reg [DELTA_TICKS];
  logic signed [VAL_W-1:0] hist_next [DELTA_TICKS];
  logic active_reg, active_next;
  logic signed [VAL_W-1:0] scaled_reg, scaled_next;
  logic signed [VAL_W-1:0] ratio_reg, ratio_next;
  logic signed [2*VAL_W-1:0] prod;
  logic signed [VAL_W-1:0] scl;
  logic signed [63:0] v, pu, h, diff, old, rel;
  logic greater, suppress, hit, clear;

  assign ch.active = active_reg;
  assign ch.scaled = scaled_reg;
  assign ch.ratio = ratio_reg;

  ////////////////////////////////////////////////////////////////////////
  // Evaluation once per program cycle; between ticks everything holds.
  always_comb begin
    // RQ2 scale the input
    prod = ch.meas * ch.scale;
    scl = prod[SCALE_FRAC +: VAL_W];
    old = 64'(hist_reg[DELTA_TICKS-1]);
    diff = 64'(scl) - old;
    pu = 64'(ch.pickup);
    // RQ10 hysteresis scaled off pick-up
    h = (pts_abs(pu) * 64'(ch.hyst)) / HYST_FULL;
    // A zero reference makes any change infinitely large in relative terms.
    rel = (old == 0) ? ((diff < 0) ? -RATIO_LIMIT : RATIO_LIMIT)
                     : (diff * HYST_FULL) / pts_abs(old);
    suppress = 1'b0;
    // RQ11 select comparator mode
    case (pts_mode_t'(ch.mode))
      MODE_OVER: begin
        v = 64'(scl);
        greater = 1'b1;
      end
      MODE_OVER_ABS: begin
        v = pts_abs(64'(scl));
        greater = 1'b1;
      end
      // RQ17 under-mode blocking limit
      MODE_UNDER: begin
        v = 64'(scl);
        greater = 1'b0;
        suppress = scl < ch.block_limit;
      end
      MODE_UNDER_ABS: begin
        v = pts_abs(64'(scl));
        greater = 1'b0;
        suppress = scl < ch.block_limit;
      end
      // RQ16 change over delta window
      MODE_REL_SGN: begin
        v = rel;
        greater = pu >= 0;
      end
      MODE_REL_ABS: begin
        v = pts_abs(rel);
        greater = 1'b1;
      end
      MODE_DELTA_SGN: begin
        v = diff;
        greater = pu >= 0;
      end
      default: begin
        v = pts_abs(diff);
        greater = 1'b1;
      end
    endcase
    // RQ9 signed pick-up comparison
    hit = greater ? (v > pu) : (v < pu);
    clear = greater ? (v < pu - h) : (v > pu + h);
    active_next = active_reg;
    scaled_next = scaled_reg;
    ratio_next = ratio_reg;
    hist_next = hist_reg;
    if (ch.tick) begin
      scaled_next = scl;
      // RQ7 ratio against pick-up
      ratio_next = pts_ratio(64'(scl), pu);
      hist_next[0] = scl;
      for (int i = 1; i < DELTA_TICKS; i++) begin
        hist_next[i] = hist_reg[i-1];
      end
      // RQ1 only selected channels act
      if (!ch.sel || suppress) begin
        active_next = 1'b0;
      end else if (hit) begin
        active_next = 1'b1;
      end else if (clear) begin
        active_next = 1'b0;
      end
    end
  end

  // Register stage.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      active_reg <= 1'b0;
      scaled_reg <= '0;
      ratio_reg <= '0;
      for (int i = 0; i < DELTA_TICKS; i++) begin
        hist_reg[i] <= '0;
      end
    end else begin
      active_reg <= active_next;
      scaled_reg <= scaled_next;
      ratio_reg <= ratio_next;
      hist_reg <= hist_next;
    end
  end
endmodule

// ### core/pts_programmable_stage.sv
// Programmable threshold stage: channels, blocking, operate/release timing.
`timescale 1ns/1ps
module pts_programmable_stage
  import pts_pkg::*;
#(
  parameter int CYCLE_CLOCKS = CYCLE_CLKS
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic stage_enable,
  input wire logic test_mode,
  input wire logic block_in,
  input wire logic [1:0] measurement_select,
  input wire logic [N_CH-1:0][VAL_W-1:0] meas_value,
  input wire logic [N_CH-1:0][VAL_W-1:0] scale_factor,
  input wire logic [N_CH-1:0][VAL_W-1:0] pickup_level,
  input wire logic [N_CH-1:0][VAL_W-1:0] block_limit,
  input wire logic [N_CH-1:0][HYST_W-1:0] reset_hysteresis,
  input wire logic [N_CH-1:0][2:0] comparator_mode_select,
  input wire logic [VAL_W-1:0] calc_pickup_level,
  input wire logic [DLY_W-1:0] op_delay_steps,
  input wire logic [DLY_W-1:0] release_delay_steps,
  output logic start_out,
  output logic trip_out,
  output logic blocked_out,
  output logic [1:0] condition_code,
  output logic [2:0] node_behaviour_code,
  output logic [TIME_W-1:0] remaining_ms,
  output logic signed [TIME_W:0] expected_ms,
  output logic [N_CH-1:0][VAL_W-1:0] scaled_value,
  output logic [N_CH-1:0][VAL_W-1:0] measured_to_setting_ratio,
  output logic [VAL_W-1:0] calculated_to_setting_ratio
);
  localparam logic [31:0] DIV_LAST = 32'(CYCLE_CLOCKS - 1);

  pts_chan_if chan [N_CH] ();
  logic [N_CH-1:0] active;
  logic [N_CH-1:0] sel;
  logic [31:0] div_reg, div_next;
  logic tick_reg, tick_next, eval_reg, eval_next;
  logic blk_reg, blk_next;
  pts_state_t st_reg, st_next;
  logic [DLY_W-1:0] op_reg, op_next, rel_reg, rel_next;
  logic start_next, trip_next, blocked_next;
  logic [2:0] node_next;
  logic [TIME_W-1:0] rem_next;
  logic signed [TIME_W:0] exp_next;
  logic [VAL_W-1:0] calc_next;
  logic signed [63:0] calc_sum;
  logic pickup, go;

  ////////////////////////////////////////////////////////////////////////
  // One comparator per channel; channel 0 always counts, channel i when i < selection.
  for (genvar i = 0; i < N_CH; i++) begin : g_ch
    assign chan[i].tick = tick_reg;
    // RQ1 selection of channel count
    assign sel[i] = (i == 0) || (2'(i) < measurement_select);
    assign chan[i].sel = sel[i];
    assign chan[i].meas = meas_value[i];
    assign chan[i].scale = scale_factor[i];
    assign chan[i].pickup = pickup_level[i];
    assign chan[i].block_limit = block_limit[i];
    assign chan[i].hyst = reset_hysteresis[i];
    assign chan[i].mode = comparator_mode_select[i];
    assign active[i] = chan[i].active;
    // RQ2 scaled value exposed
    assign scaled_value[i] = chan[i].scaled;
    assign measured_to_setting_ratio[i] = chan[i].ratio;
    pts_comparator u_cmp (
      .clk(clk),
      .reset_n(reset_n),
      .ch(chan[i].cmp)
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Program cycle divider; the comparators run on tick, the timer one
  // clock later so it sees their freshly updated pick-up flags.
  always_comb begin
    // RQ12 one tick per step
    tick_next = (div_reg == DIV_LAST);
    div_next = tick_next ? 32'h0000_0000 : div_reg + 32'h0000_0001;
    eval_next = tick_reg;
    // RQ15 block sampled at cycle start
    blk_next = tick_reg ? block_in : blk_reg;
    calc_sum = '0;
    // The loop reads plain vectors, since an interface array takes only
    // constant indices.
    for (int i = 0; i < N_CH; i++) begin
      if (sel[i]) begin
        calc_sum = calc_sum + 64'($signed(scaled_value[i]));
      end
    end
    // RQ8 combined magnitude ratio
    calc_next = eval_reg ? pts_ratio(calc_sum, 64'($signed(calc_pickup_level)))
                         : calculated_to_setting_ratio;
  end

  ////////////////////////////////////////////////////////////////////////
  // Stage timer. A release in progress keeps start asserted.
  always_comb begin
    st_next = st_reg;
    op_next = op_reg;
    rel_next = rel_reg;
    pickup = |active;
    // RQ13 start needs blocking clear
    go = pickup && !blk_reg;
    if (!stage_enable) begin
      st_next = ST_NORMAL;
      op_next = '0;
      rel_next = '0;
    end else if (eval_reg) begin
      case (st_reg)
        ST_NORMAL, ST_BLOCKED: begin
          op_next = '0;
          rel_next = '0;
          if (go) begin
            st_next = (op_delay_steps == '0) ? ST_TRIP : ST_START;
          end else if (pickup) begin
            // RQ14 blocked at pick-up
            st_next = ST_BLOCKED;
          end else begin
            st_next = ST_NORMAL;
          end
        end
        ST_START, ST_TRIP: begin
          if (go) begin
            rel_next = '0;
            if (st_reg == ST_START) begin
              op_next = op_reg + 1'b1;
              // RQ18 trip after operate delay
              if (op_next >= op_delay_steps) begin
                st_next = ST_TRIP;
              end
            end
          end else if (rel_reg + 1'b1 >= release_delay_steps) begin
            // RQ19 release after delay
            st_next = pickup ? ST_BLOCKED : ST_NORMAL;
            op_next = '0;
            rel_next = '0;
          end else begin
            // RQ14 blocked start follows release
            rel_next = rel_reg + 1'b1;
          end
        end
        default: begin
          st_next = ST_NORMAL;
        end
      endcase
    end
    // RQ4 condition follows state
    start_next = (st_next == ST_START) || (st_next == ST_TRIP);
    trip_next = st_next == ST_TRIP;
    blocked_next = st_next == ST_BLOCKED;
    // RQ5 remaining time, zero tripped
    if (st_next == ST_START && rel_next == '0) begin
      rem_next = TIME_W'(op_delay_steps - op_next) * STEP_MS_W;
    end else begin
      rem_next = '0;
    end
    // RQ6 expected operating time
    exp_next = $signed({1'b0, TIME_W'(op_delay_steps) * STEP_MS_W});
    // RQ3 node behaviour code
    if (!stage_enable) begin
      node_next = NB_OFF;
    end else if (test_mode) begin
      node_next = blk_reg ? NB_TEST_BLOCKED : NB_TEST;
    end else begin
      node_next = blk_reg ? NB_BLOCKED : NB_ON;
    end
  end

  // Register stage for divider, timer and outputs.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
      eval_reg <= 1'b0;
      blk_reg <= 1'b0;
      st_reg <= ST_NORMAL;
      op_reg <= '0;
      rel_reg <= '0;
      start_out <= 1'b0;
      trip_out <= 1'b0;
      blocked_out <= 1'b0;
      condition_code <= ST_NORMAL;
      node_behaviour_code <= NB_OFF;
      remaining_ms <= '0;
      expected_ms <= '0;
      calculated_to_setting_ratio <= '0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
      eval_reg <= eval_next;
      blk_reg <= blk_next;
      st_reg <= st_next;
      op_reg <= op_next;
      rel_reg <= rel_next;
      start_out <= start_next;
      trip_out <= trip_next;
      blocked_out <= blocked_next;
      condition_code <= st_next;
      node_behaviour_code <= node_next;
      remaining_ms <= rem_next;
      expected_ms <= exp_next;
      calculated_to_setting_ratio <= calc_next;
    end
  end
endmodule

// ### testbench/pts_stage_checker.sv
// Port assertions for the programmable threshold stage.
`timescale 1ns/1ps
module pts_stage_checker
  import pts_pkg::*;
#(
  parameter int CYCLE_CLOCKS = 20
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic stage_enable,
  input wire logic test_mode,
  input wire logic block_in,
  input wire logic [DLY_W-1:0] op_delay_steps,
  input wire logic start_out,
  input wire logic trip_out,
  input wire logic blocked_out,
  input wire logic [1:0] condition_code,
  input wire logic [2:0] node_behaviour_code,
  input wire logic [TIME_W-1:0] remaining_ms
);
  // Three program cycles between start and trip.
  localparam int TRIP_GAP = 3 * CYCLE_CLOCKS;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_blk; blocked_out |-> !start_out && condition_code == 2'h3;
  endproperty
  a_blk: assert property (p_blk) else $error("blocked with start");
  property p_norm;
    condition_code == 2'h0 |-> !start_out && !trip_out && !blocked_out;
  endproperty
  a_norm: assert property (p_norm) else $error("normal not idle");
  property p_off; !stage_enable |=> node_behaviour_code == 3'h5; endproperty
  a_off: assert property (p_off) else $error("off code wrong");
  property p_test;
    stage_enable && test_mode |=> node_behaviour_code inside {3'h3, 3'h4};
  endproperty
  a_test: assert property (p_test) else $error("test code wrong");
  property p_trip; trip_out |-> start_out && remaining_ms == '0; endproperty
  a_trip: assert property (p_trip) else $error("trip state wrong");
  property p_fell; $fell(start_out) |-> !trip_out; endproperty
  a_fell: assert property (p_fell) else $error("trip outlived start");
  property p_idle; !start_out |-> remaining_ms == '0; endproperty
  a_idle: assert property (p_idle) else $error("remaining not zero");
  property p_go; $rose(start_out) |-> !$past(block_in, 2); endproperty
  a_go: assert property (p_go) else $error("start while blocked");
  property p_bl; $rose(blocked_out) |-> $past(block_in, 2); endproperty
  a_bl: assert property (p_bl) else $error("blocked without block");
  property p_rem;
    $rose(start_out) && !trip_out |->
      remaining_ms == TIME_W'(op_delay_steps) * STEP_MS_W;
  endproperty
  a_rem: assert property (p_rem) else $error("remaining at start");
  property p_gap;
    $rose(start_out) && !trip_out && !block_in && op_delay_steps == 19'h3
      |-> ##TRIP_GAP $rose(trip_out);
  endproperty
  a_gap: assert property (p_gap) else $error("trip delay wrong");
endmodule
bind pts_programmable_stage pts_stage_checker #(
  .CYCLE_CLOCKS(CYCLE_CLOCKS)
) u_pts_stage_checker (
  .clk(clk), .reset_n(reset_n), .stage_enable(stage_enable),
  .test_mode(test_mode), .block_in(block_in),
  .op_delay_steps(op_delay_steps), .start_out(start_out),
  .trip_out(trip_out), .blocked_out(blocked_out),
  .condition_code(condition_code),
  .node_behaviour_code(node_behaviour_code), .remaining_ms(remaining_ms)
);

// ### testbench/pts_meas_source.sv
// Measurement processing and blocking matrix seen by the stage.
`timescale 1ns/1ps
module pts_meas_source
  import pts_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [N_CH-1:0][VAL_W-1:0] value_req,
  input wire logic block_req,
  output logic [N_CH-1:0][VAL_W-1:0] meas_value,
  output logic block_in
);
  // Values are republished every clock; block stays a steady level.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meas_value <= '0;
      block_in <= 1'b0;
    end else begin
      meas_value <= value_req;
      block_in <= block_req;
    end
  end
endmodule

// ### testbench/testbench.sv
// Self-checking bench of the programmable threshold stage.
`timescale 1ns/1ps
module testbench;
  import pts_pkg::*;
  localparam int CYC = 20;
  typedef struct {
    int mode, ma, mb, sc, pu, lim, hit;
  } pts_row_t;
  logic clk = 1'b0;
  logic reset_n, stage_enable, test_mode, block_req, block_in, seen;
  logic [1:0] measurement_select, condition_code;
  logic [N_CH-1:0][VAL_W-1:0] val_req, meas_value, scale_factor;
  logic [N_CH-1:0][VAL_W-1:0] pickup_level, block_limit, scaled_value;
  logic [N_CH-1:0][VAL_W-1:0] measured_to_setting_ratio;
  logic [N_CH-1:0][HYST_W-1:0] reset_hysteresis;
  logic [N_CH-1:0][2:0] comparator_mode_select;
  logic [VAL_W-1:0] calc_pickup_level, calculated_to_setting_ratio;
  logic [DLY_W-1:0] op_delay_steps, release_delay_steps;
  logic start_out, trip_out, blocked_out;
  logic [2:0] node_behaviour_code;
  logic [TIME_W-1:0] remaining_ms;
  logic signed [TIME_W:0] expected_ms;
  int n_fail = 0;
  int checks_done = 0;
  // Mode, value before, value after, scale, pick-up, limit, start seen.
  pts_row_t rows[14] = '{
    '{0, 200, 200, 1, 100, 0, 1}, '{0, 50, 50, 1, 100, 0, 0},
    '{0, 60, 60, 2, 100, 0, 1}, '{0, -50, -50, 1, -100, 0, 1},
    '{1, -200, -200, 1, 100, 0, 1}, '{2, 50, 50, 1, 100, 0, 1},
    '{2, 50, 50, 1, 100, 60, 0}, '{3, -50, -50, 1, 100, -1000, 1},
    '{4, 10000, 12000, 1, 100000, 0, 1}, '{4, 10000, 8000, 1, 100000, 0, 0},
    '{5, 10000, 8000, 1, 100000, 0, 1}, '{6, 10000, 12000, 1, 1000, 0, 1},
    '{6, 10000, 8000, 1, 1000, 0, 0}, '{7, 10000, 8000, 1, 1000, 0, 1}};
  always #5 clk = ~clk;
  pts_meas_source u_pts_meas_source (.clk(clk), .reset_n(reset_n),
    .value_req(val_req), .block_req(block_req), .meas_value(meas_value),
    .block_in(block_in));
  pts_programmable_stage #(.CYCLE_CLOCKS(CYC)) u_pts_programmable_stage (
    .clk(clk), .reset_n(reset_n), .stage_enable(stage_enable),
    .test_mode(test_mode), .block_in(block_in),
    .measurement_select(measurement_select), .meas_value(meas_value),
    .scale_factor(scale_factor), .pickup_level(pickup_level),
    .block_limit(block_limit), .reset_hysteresis(reset_hysteresis),
    .comparator_mode_select(comparator_mode_select),
    .calc_pickup_level(calc_pickup_level), .op_delay_steps(op_delay_steps),
    .release_delay_steps(release_delay_steps), .start_out(start_out),
    .trip_out(trip_out), .blocked_out(blocked_out),
    .condition_code(condition_code),
    .node_behaviour_code(node_behaviour_code), .remaining_ms(remaining_ms),
    .expected_ms(expected_ms), .scaled_value(scaled_value),
    .measured_to_setting_ratio(measured_to_setting_ratio),
    .calculated_to_setting_ratio(calculated_to_setting_ratio));
  ////////////////////////////////////////////////////////////////////////////
  // Compares with case equality so an unknown never passes.
  task automatic chk(logic [VAL_W-1:0] got, logic [VAL_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ticks(int n);
    repeat (n * CYC) @(posedge clk);
  endtask
  // Baseline: stage on, channel 0 only, unit scale, zero delays.
  task automatic base();
    stage_enable <= 1'b1;
    test_mode <= 1'b0;
    block_req <= 1'b0;
    measurement_select <= 2'h1;
    val_req <= '0;
    scale_factor <= {N_CH{VAL_W'(65536)}};
    pickup_level <= {N_CH{PICKUP_DEFAULT}};
    block_limit <= '0;
    reset_hysteresis <= {N_CH{HYST_DEFAULT}};
    comparator_mode_select <= '0;
    calc_pickup_level <= PICKUP_DEFAULT;
    op_delay_steps <= '0;
    release_delay_steps <= '0;
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (12) @(posedge clk);
    chk(node_behaviour_code, 5);
    chk(start_out, 0);
    reset_n <= 1'b1;
  endtask
  // Bounded wait for start; the caller checks that it came.
  task automatic wait_start();
    int k;
    k = 0;
    while (start_out !== 1'b1 && k < 200) begin
      @(posedge clk);
      k++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Cuts a hang short well beyond the expected run time.
  initial begin
    #500000;
    n_fail++;
    summarize();
  end
  initial begin
    base();
    foreach (rows[i]) begin
      base();
      do_reset();
      comparator_mode_select[0] <= rows[i].mode[2:0];
      scale_factor[0] <= VAL_W'(rows[i].sc * 65536);
      pickup_level[0] <= VAL_W'(rows[i].pu);
      block_limit[0] <= VAL_W'(rows[i].lim);
      val_req[0] <= VAL_W'(rows[i].ma);
      ticks(10);
      val_req[0] <= VAL_W'(rows[i].mb);
      seen = 1'b0;
      repeat (8 * CYC) begin
        @(posedge clk);
        seen = seen | start_out;
      end
      chk(seen, rows[i].hit[0]);
      chk(scaled_value[0], VAL_W'(longint'(rows[i].mb) * rows[i].sc));
      chk(measured_to_setting_ratio[0], VAL_W'(longint'(rows[i].mb) *
        rows[i].sc * 10000 / rows[i].pu));
    end
    // Three-step operate delay, two-step release, hysteresis hold.
    base();
    do_reset();
    op_delay_steps <= 19'h3;
    release_delay_steps <= 19'h2;
    val_req[0] <= VAL_W'(200);
    wait_start();
    chk(start_out, 1);
    chk(remaining_ms, 15);
    chk(expected_ms, 15);
    ticks(4);
    chk(trip_out, 1);
    val_req[0] <= VAL_W'(98);
    ticks(3);
    chk(start_out, 1);
    val_req[0] <= VAL_W'(50);
    ticks(1);
    chk(trip_out, 1);
    ticks(4);
    chk(start_out, 0);
    chk(trip_out, 0);
    // Blocking before pick-up, then arriving during an active start.
    base();
    do_reset();
    block_req <= 1'b1;
    val_req[0] <= VAL_W'(200);
    ticks(3);
    chk(condition_code, 3);
    chk(node_behaviour_code, 2);
    chk(start_out, 0);
    block_req <= 1'b0;
    ticks(3);
    chk(condition_code, 2);
    block_req <= 1'b1;
    ticks(4);
    chk(start_out, 0);
    chk(blocked_out, 1);
    test_mode <= 1'b1;
    ticks(1);
    chk(node_behaviour_code, 4);
    // Channel selection, combined ratio and zero pick-up clamp.
    base();
    do_reset();
    val_req <= {VAL_W'(700), VAL_W'(500), VAL_W'(50)};
    calc_pickup_level <= VAL_W'(1000);
    ticks(3);
    chk(start_out, 0);
    chk(node_behaviour_code, 1);
    chk(calculated_to_setting_ratio, 500);
    measurement_select <= 2'h3;
    pickup_level[2] <= '0;
    ticks(3);
    chk(start_out, 1);
    chk(measured_to_setting_ratio[1], 50000);
    chk(scaled_value[1], 500);
    chk(measured_to_setting_ratio[2],
      VAL_W'(longint'(5000000) * 10000));
    chk(calculated_to_setting_ratio, 12500);
    test_mode <= 1'b1;
    ticks(1);
    chk(node_behaviour_code, 3);
    stage_enable <= 1'b0;
    ticks(2);
    chk(node_behaviour_code, 5);
    chk(condition_code, 0);
    summarize();
  end
endmodule
